// *** src/sls_cfg.svh ***
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH
// Notes on behaviour
// - Code minus one is an empty line; nothing happens, step on.
// - Code minus two selects OR mode for following signal lines.
// - Code minus three selects AND mode for following signal lines.
// - Minus four inverts the working bit; minus six clears it.
// - Minus five copies the working bit to the next result output.
// - Minus seven ends the pass; programs must end with it.
// - Runs only while enabled; programmer disables before editing.
// - Signal lines carry identifiers 1 to 359 selecting one status bit.
// - Identifier 3 is a seconds square wave toggling every 1000 ms.
// - Identifiers 4, 5, 6 show sample, zero, span valve selected.
// - Identifiers 7, 8, 9 show failure, check request, function check.
// - Result outputs read back as identifiers 40 to 59 in order.
// - Result outputs one to twenty are visible for inspection.
// - Only own analyzer signals are accepted; others read as zero.
`define SLS_CODE_NO_OPERATION 16'hFFFF
`define SLS_CODE_OR        16'hFFFE
`define SLS_CODE_AND       16'hFFFD
`define SLS_CODE_INVERT    16'hFFFC
`define SLS_CODE_STORE     16'hFFFB
`define SLS_CODE_CLEAR     16'hFFFA
`define SLS_CODE_END       16'hFFF9
`define SLS_SIG_MAX        16'h0167
`define SLS_SIG_SECONDS    16'h0003
`define SLS_SIG_RES_FIRST  16'h0028
`define SLS_SIG_RES_LAST   16'h003B
`define SLS_HALF_PERIOD_MS 1000
`define SLS_CLK_MHZ        250
`define SLS_HALF_CYCLES    (`SLS_HALF_PERIOD_MS * 1000 * `SLS_CLK_MHZ)
`define SLS_PROG_LINES     64
`define SLS_ADDR_W         6
`define SLS_RESULTS        20
`define SLS_INTR_BITS      2
`define SLS_REG_CTRL       8'h00
`define SLS_REG_STATUS     8'h01
`define SLS_REG_MASK       8'h02
`define SLS_REG_RESULTS    8'h03
`define SLS_REG_PROG_ADDR  8'h04
`define SLS_REG_PROG_DATA  8'h05
`define SLS_REG_RESULTS_HI 8'h06
`endif

// *** src/sls_pkg.sv ***
package sls_pkg;
    typedef enum logic [1:0] {SLS_IDLE, SLS_FETCH, SLS_EXEC} sls_state_type;
    typedef enum logic {SLS_MODE_OR, SLS_MODE_AND} sls_mode_type;
endpackage

// *** src/sls_prog_mem.sv ***
`timescale 1ns/1ns
module sls_prog_mem (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [5:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [5:0]  rd_addr,
    output logic      [15:0] rd_data
);
    logic [15:0] mem [0:63];
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** src/sls_sync.sv ***
`timescale 1ns/1ns
module sls_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic meta;
        logic level;
    } sls_sync_regs_type;

    sls_sync_regs_type r_q;
    sls_sync_regs_type r_d;

    // Only the second stage is read outside this module
    always_comb begin
        r_d.meta  = din;
        r_d.level = r_q.meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign dout = r_q.level;
endmodule

// *** src/status_logic_sequencer.sv ***
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "sls_cfg.svh"
module status_logic_sequencer #(
    parameter int unsigned HALF_CYCLES = `SLS_HALF_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        ram_fail,
    input  wire logic        rom_fail,
    input  wire logic        sample_valve,
    input  wire logic        zero_valve,
    input  wire logic        span_valve,
    input  wire logic        stat_failure,
    input  wire logic        stat_check_req,
    input  wire logic        stat_func_check,
    output logic      [19:0] result_out,
    output logic             seconds_out,
    output logic             busy,
    output logic             irq
);
    typedef struct packed {
        sls_pkg::sls_state_type state;
        sls_pkg::sls_mode_type  mode;
        logic                   work;
        logic [5:0]             pc;
        logic [4:0]             store_idx;
        logic [19:0]            results;
        logic                   enable;
        logic [5:0]             prog_addr;
        logic [1:0]             status;
        logic [1:0]             mask;
        logic [31:0]            sec_cnt;
        logic                   seconds;
        logic [15:0]            rdata;
        logic                   busy;
        logic                   irq;
    } sls_regs_type;

    sls_regs_type r_q;
    sls_regs_type r_d;

    logic [15:0] line_code;
    logic [8:0]  sig_s;
    logic [19:0] res_sel;

    sls_sync u_s0 (.clk(clk), .sys_rst(sys_rst), .din(ram_fail),        .dout(sig_s[0]));
    sls_sync u_s1 (.clk(clk), .sys_rst(sys_rst), .din(rom_fail),        .dout(sig_s[1]));
    sls_sync u_s3 (.clk(clk), .sys_rst(sys_rst), .din(sample_valve),    .dout(sig_s[3]));
    sls_sync u_s4 (.clk(clk), .sys_rst(sys_rst), .din(zero_valve),      .dout(sig_s[4]));
    sls_sync u_s5 (.clk(clk), .sys_rst(sys_rst), .din(span_valve),      .dout(sig_s[5]));
    sls_sync u_s6 (.clk(clk), .sys_rst(sys_rst), .din(stat_failure),    .dout(sig_s[6]));
    sls_sync u_s7 (.clk(clk), .sys_rst(sys_rst), .din(stat_check_req),  .dout(sig_s[7]));
    sls_sync u_s8 (.clk(clk), .sys_rst(sys_rst), .din(stat_func_check), .dout(sig_s[8]));
    assign sig_s[2] = 1'b0;

    sls_prog_mem u_mem (
        .clk     (clk),
        .wr_en   (reg_wr && reg_addr == `SLS_REG_PROG_DATA && !r_q.enable),
        .wr_addr (r_q.prog_addr),
        .wr_data (reg_wdata),
        .rd_addr (r_q.pc),
        .rd_data (line_code)
    );

    function automatic logic operand(input logic [15:0] id, input logic [8:0] s, input logic [19:0] res,
                                     input logic sec);
        logic v;
        v = 1'b0;
        if (id == `SLS_SIG_SECONDS) begin
            v = sec;
        end else if (id >= 16'h0001 && id <= 16'h0009) begin
            v = s[4'(id - 16'h0001)];
        end else if (id >= `SLS_SIG_RES_FIRST && id <= `SLS_SIG_RES_LAST) begin
            v = res[5'(id - `SLS_SIG_RES_FIRST)];
        end
        return v;
    endfunction

    always_comb begin
        logic op;
        logic [1:0] ev;
        op = operand(line_code, sig_s, r_q.results, r_q.seconds);
        ev = 2'h0;
        r_d = r_q;
        r_d.rdata = 16'h0000;
        if (r_q.sec_cnt == HALF_CYCLES - 1) begin
            r_d.sec_cnt = 32'h00000000;
            r_d.seconds = ~r_q.seconds;
        end else begin
            r_d.sec_cnt = r_q.sec_cnt + 32'h00000001;
        end
        unique case (r_q.state)
            sls_pkg::SLS_IDLE: begin
                if (r_q.enable) begin
                    r_d.pc = 6'h00;
                    r_d.store_idx = 5'h00;
                    r_d.state = sls_pkg::SLS_FETCH;
                end
            end
            sls_pkg::SLS_FETCH: begin
                r_d.state = sls_pkg::SLS_EXEC;
            end
            sls_pkg::SLS_EXEC: begin
                r_d.state = sls_pkg::SLS_FETCH;
                r_d.pc = r_q.pc + 6'h01;
                case (line_code)
                    `SLS_CODE_NO_OPERATION: ;
                    `SLS_CODE_OR: r_d.mode = sls_pkg::SLS_MODE_OR;
                    `SLS_CODE_AND: r_d.mode = sls_pkg::SLS_MODE_AND;
                    `SLS_CODE_INVERT: r_d.work = ~r_q.work;
                    `SLS_CODE_CLEAR: r_d.work = 1'b0;
                    `SLS_CODE_STORE: begin
                        if (r_q.store_idx < 5'(`SLS_RESULTS)) begin
                            r_d.results[r_q.store_idx] = r_q.work;
                            r_d.store_idx = r_q.store_idx + 5'h01;
                        end
                    end
                    `SLS_CODE_END: begin
                        r_d.state = sls_pkg::SLS_IDLE;
                        ev[0] = 1'b1;
                    end
                    default: begin
                        if (line_code >= 16'h0001 && line_code <= `SLS_SIG_MAX) begin
                            r_d.work = (r_q.mode == sls_pkg::SLS_MODE_OR) ? (r_q.work | op) : (r_q.work & op);
                        end else begin
                            ev[1] = 1'b1;
                        end
                    end
                endcase
                if (r_q.pc == 6'h3F && line_code != `SLS_CODE_END) begin
                    r_d.state = sls_pkg::SLS_IDLE;
                    ev[1] = 1'b1;
                end
                if (!r_q.enable) begin
                    r_d.state = sls_pkg::SLS_IDLE;
                end
            end
            default: r_d.state = sls_pkg::SLS_IDLE;
        endcase
        if (reg_wr) begin
            unique case (reg_addr)
                `SLS_REG_CTRL: r_d.enable = reg_wdata[0];
                `SLS_REG_STATUS: r_d.status = r_q.status & ~reg_wdata[1:0];
                `SLS_REG_MASK: r_d.mask = reg_wdata[1:0];
                `SLS_REG_PROG_ADDR: r_d.prog_addr = reg_wdata[5:0];
                `SLS_REG_PROG_DATA: r_d.prog_addr = r_q.prog_addr + 6'h01;
                default: ;
            endcase
        end
        r_d.status = r_d.status | ev;
        if (reg_rd) begin
            unique case (reg_addr)
                `SLS_REG_CTRL: r_d.rdata = {14'h0000, r_q.busy, r_q.enable};
                `SLS_REG_STATUS: r_d.rdata = {14'h0000, r_q.status};
                `SLS_REG_MASK: r_d.rdata = {14'h0000, r_q.mask};
                `SLS_REG_RESULTS: r_d.rdata = r_q.results[15:0];
                `SLS_REG_PROG_ADDR: r_d.rdata = {10'h000, r_q.prog_addr};
                `SLS_REG_RESULTS_HI: r_d.rdata = {12'h000, r_q.results[19:16]};
                default: r_d.rdata = 16'h0000;
            endcase
        end
        r_d.busy = (r_d.state != sls_pkg::SLS_IDLE);
        r_d.irq = |(r_d.status & r_d.mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign reg_rdata   = r_q.rdata;
    assign result_out  = r_q.results;
    assign seconds_out = r_q.seconds;
    assign busy        = r_q.busy;
    assign irq         = r_q.irq;
endmodule

// *** test/sls_chk.sv ***
`timescale 1ns/1ns
`include "sls_cfg.svh"
module sls_chk #(
    parameter int unsigned HALF_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [19:0] result_out,
    input wire logic        seconds_out,
    input wire logic        busy,
    input wire logic        irq
);
    logic [31:0] cnt_q;
    logic        prev_q;
    logic        seen_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Cycles since the last toggle of the seconds wave
    always_ff @(posedge clk) begin
        prev_q <= seconds_out;
        cnt_q  <= (seconds_out != prev_q) ? 32'h0 : cnt_q + 32'h1;
        seen_q <= sys_rst ? 1'b0 : (seen_q | (seconds_out != prev_q));
    end
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_lo; reg_rd && reg_addr == `SLS_REG_RESULTS |=> reg_rdata == $past(result_out[15:0]); endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("low results read wrong");
    property p_rd_hi;
        reg_rd && reg_addr == `SLS_REG_RESULTS_HI |=> reg_rdata == {12'h000, $past(result_out[19:16])};
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("high results read wrong");
    property p_rd_void; reg_rd && reg_addr > `SLS_REG_RESULTS_HI |=> reg_rdata == 16'h0000; endproperty
    a_rd_void: assert property (p_rd_void) else $error("unmapped read not zero");
    property p_res_hold; !busy && !$past(busy) |-> $stable(result_out); endproperty
    a_res_hold: assert property (p_res_hold) else $error("results moved while idle");
    property p_sec_edge; seen_q && seconds_out != prev_q |-> cnt_q == HALF_CYCLES - 1; endproperty
    a_sec_edge: assert property (p_sec_edge) else $error("seconds toggle early");
    property p_sec_run; seen_q |-> cnt_q < HALF_CYCLES; endproperty
    a_sec_run: assert property (p_sec_run) else $error("seconds toggle late");
    property p_rst; disable iff (1'b0) sys_rst |=> !irq && !busy && result_out == 20'h00000; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_mask; reg_wr && reg_addr == `SLS_REG_MASK && reg_wdata[1:0] == 2'h0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt still high");
    c_pass: cover property ($fell(busy));
    c_irq: cover property ($rose(irq));
    c_rd: cover property (reg_rd && reg_addr == `SLS_REG_RESULTS);
endmodule
bind status_logic_sequencer sls_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .result_out(result_out), .seconds_out(seconds_out), .busy(busy), .irq(irq));

// *** test/sls_operator.sv ***
`timescale 1ns/1ns
`include "sls_cfg.svh"
module sls_operator (
    input  wire logic        clk,
    input  wire logic [15:0] reg_rdata,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // Edits only while stopped, operators before their signals, end code last
    task automatic load(input logic [15:0] prog [$]);
        wr(`SLS_REG_CTRL, 16'h0000);
        wr(`SLS_REG_PROG_ADDR, 16'h0000);
        foreach (prog[i]) wr(`SLS_REG_PROG_DATA, prog[i]);
        wr(`SLS_REG_PROG_DATA, `SLS_CODE_END);
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
`include "sls_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk = 1'b0;
    logic        sys_rst, sample_valve, zero_valve, span_valve, rom_fail, reg_wr, reg_rd;
    logic        ram_fail, stat_failure, stat_check_req, stat_func_check;
    logic        seconds_out, busy, irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [19:0] result_out;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [15:0] prog_a [$] = '{`SLS_CODE_CLEAR, `SLS_CODE_OR, 16'h0005, 16'h0004, `SLS_CODE_STORE,
        `SLS_CODE_AND, 16'h0006, 16'h0002, `SLS_CODE_STORE, `SLS_CODE_INVERT, `SLS_CODE_STORE, `SLS_CODE_CLEAR,
        `SLS_CODE_NO_OPERATION, `SLS_CODE_STORE, `SLS_CODE_OR, 16'h0028, `SLS_CODE_STORE, `SLS_CODE_CLEAR, 16'h000A,
        `SLS_CODE_INVERT, `SLS_CODE_STORE};
    initial forever #2 clk = ~clk;
    status_logic_sequencer #(.HALF_CYCLES(10)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_fail(ram_fail),
        .rom_fail(rom_fail), .sample_valve(sample_valve), .zero_valve(zero_valve), .span_valve(span_valve),
        .stat_failure(stat_failure), .stat_check_req(stat_check_req), .stat_func_check(stat_func_check),
        .result_out(result_out),
        .seconds_out(seconds_out), .busy(busy), .irq(irq));
    sls_operator u_op (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_pass();
        logic [15:0] s;
        int n;
        s = 16'h0000;
        n = 0;
        u_op.wr(`SLS_REG_STATUS, 16'h0003);
        while (s[0] !== 1'b1 && n < 200) begin
            u_op.rd(`SLS_REG_STATUS, s);
            n++;
        end
        `CHK(s[0], 1'b1)
    endtask
    task automatic t_combine();
        u_op.load(prog_a);
        u_op.wr(`SLS_REG_CTRL, 16'h0001);
        wait_pass();
        wait_pass();
        `CHK(result_out, 20'h00035)
        u_op.rd(`SLS_REG_RESULTS, d);
        `CHK(d, 16'h0035)
        u_op.rd(`SLS_REG_RESULTS_HI, d);
        `CHK(d, 16'h0000)
        u_op.rd(8'h07, d);
        `CHK(d, 16'h0000)
        u_op.rd(`SLS_REG_CTRL, d);
        `CHK(d[0], 1'b1)
    endtask
    task automatic t_disable();
        u_op.wr(`SLS_REG_CTRL, 16'h0000);
        sample_valve <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(result_out, 20'h00035)
        u_op.wr(`SLS_REG_CTRL, 16'h0001);
        wait_pass();
        wait_pass();
        `CHK(result_out, 20'h00024)
    endtask
    task automatic t_irq();
        u_op.wr(`SLS_REG_MASK, 16'h0001);
        wait_pass();
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        u_op.wr(`SLS_REG_CTRL, 16'h0000);
        repeat (4) @(posedge clk);
        u_op.wr(`SLS_REG_STATUS, 16'h0003);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        u_op.wr(`SLS_REG_MASK, 16'h0000);
    endtask
    task automatic t_flags();
        logic [15:0] p [$];
        p = '{`SLS_CODE_CLEAR, `SLS_CODE_OR, 16'h0007, `SLS_CODE_STORE, `SLS_CODE_CLEAR, 16'h0008, `SLS_CODE_STORE,
            `SLS_CODE_CLEAR, 16'h0009, `SLS_CODE_STORE, `SLS_CODE_CLEAR, 16'h0001, `SLS_CODE_STORE, 16'h0000};
        repeat (16) p.push_back(`SLS_CODE_STORE);
        ram_fail <= 1'b1;
        stat_failure <= 1'b1;
        stat_func_check <= 1'b1;
        u_op.load(p);
        u_op.wr(`SLS_REG_CTRL, 16'h0001);
        wait_pass();
        wait_pass();
        `CHK(result_out, 20'hFFFFD)
        u_op.rd(`SLS_REG_RESULTS, d);
        `CHK(d, 16'hFFFD)
        u_op.rd(`SLS_REG_RESULTS_HI, d);
        `CHK(d, 16'h000F)
        u_op.rd(`SLS_REG_STATUS, d);
        `CHK(d[1], 1'b1)
        u_op.wr(`SLS_REG_MASK, 16'h0002);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        u_op.wr(`SLS_REG_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        u_op.wr(`SLS_REG_CTRL, 16'h0000);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        sys_rst = 1'b1;
        sample_valve = 1'b1;
        zero_valve = 1'b0;
        span_valve = 1'b1;
        rom_fail = 1'b0;
        ram_fail = 1'b0;
        stat_failure = 1'b0;
        stat_check_req = 1'b0;
        stat_func_check = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_combine();
        t_disable();
        t_irq();
        t_flags();
        conclude();
    end
endmodule
